// ---- rtl/timer_pkg.sv ----
/*
  constants of the dual mode compare timer: register offsets, field
  positions, reset values.
  assumes an 8-bit peripheral bus addressing by the low address nibble.
*/
package timer_pkg;
  // register offsets (low nibble of the peripheral address)
  localparam logic [3:0] OFF_CTRL  = 4'h6;
  localparam logic [3:0] OFF_STAT  = 4'h7;
  localparam logic [3:0] OFF_CNT_H = 4'h8;
  localparam logic [3:0] OFF_CNT_L = 4'h9;
  localparam logic [3:0] OFF_CMP_H = 4'hA;
  localparam logic [3:0] OFF_CMP_L = 4'hB;
  // timer_control fields
  localparam int B_TOL_H = 7;
  localparam int B_SEL_H = 4;
  localparam int B_TOL_L = 3;
  localparam int B_SEL_L = 0;
  // timer_status_control fields
  localparam int B_OVF_H  = 7;
  localparam int B_CMF_H  = 6;
  localparam int B_OVIE_H = 5;
  localparam int B_CCLR_H = 4;
  localparam int B_OVF_L  = 3;
  localparam int B_CMF_L  = 2;
  localparam int B_OVIE_L = 1;
  localparam int B_CCLR_L = 0;
  localparam logic [7:0] FLAG_MASK = 8'hCC;
  // reset values, counter top value, unmapped read value
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h00;
  localparam logic [7:0] RST_CNT  = 8'h00;
  localparam logic [7:0] RST_CMP  = 8'hFF;
  localparam logic [7:0] CNT_TOP  = 8'hFF;
  localparam logic [7:0] RD_NONE  = 8'hFF;
  // clock select low bits: divide 32, 16, 4, 2
  localparam logic [1:0] SEL_D32 = 2'h0;
  localparam logic [1:0] SEL_D16 = 2'h1;
  localparam logic [1:0] SEL_D4  = 2'h2;
  localparam logic [1:0] SEL_D2  = 2'h3;
endpackage

// ---- rtl/count_half.sv ----
/*
  one 8-bit half of the timer counter: count, clear, load.
  assumes tick, clear and load come from the parent in the same clock.
*/
`timescale 1ns/1ps
module count_half (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_tick,
  input  wire logic       i_clear,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic [7:0]      o_count,
  output logic            o_wrap
);
  logic [7:0] count_reg;

  assign o_count = count_reg;
  // a write or a clear in the same cycle swallows the wrap
  assign o_wrap = i_tick & ~i_clear & ~i_wr &
                  (count_reg == timer_pkg::CNT_TOP);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= timer_pkg::RST_CNT;
    end else if (i_wr) begin
      count_reg <= i_wdata;
    end else if (i_clear) begin
      count_reg <= 8'h00;
    end else if (i_tick) begin
      count_reg <= count_reg + 8'h01;
    end
  end
endmodule

// ---- rtl/dual_mode_compare_timer.sv ----
/*
  dual mode compare timer: one 16-bit counter or two 8-bit counters,
  compare, flags, toggle pins, interrupt request pulses.
  assumes an 8-bit cpu bus with one-cycle read and write strobes,
  inputs synchronous to i_clk_sys, i_run high in active and sleep.
*/
`timescale 1ns/1ps
// Functional notes
// - upper overflow flag set on upper wrap; cleared by 0 after read 1
// - upper match flag set on upper match; software only clears it
// - overflow interrupt enable bits 5 and 1, reset to zero
// - upper clear enable clears whole counter (16-bit) or upper half
// - lower overflow flag set on lower wrap; read-1-write-0 clears
// - lower match flag set on lower match; read-1-write-0 clears
// - lower clear enable clears lower counter on its match in 8-bit mode
// - status register resets to zero
// - 16-bit write: upper byte to latch, lower write moves both
// - in 16-bit mode upper counter read captures lower byte; lower read returns it
// - compare reads return register bytes directly
// - upper clock select msb picks 16-bit or two 8-bit counters
// - reset: counter zero, compare all ones, control zero, event clock
// - 16-bit match sets flag, toggles upper pin, irq, optional clear
// - 16-bit overflow sets flag; irq needs both enables
// - internal clocks divide by 32, 16, 4 or 2
// - lower counter counts selected event edge; irq pulses last one clock
// - toggle pin shows level bit, inverts on each match
// - match fires when counter advances off the matching value
// - counter runs only when i_run; registers always retained
// - 8-bit match per half: flag, irq, toggle, optional clear
// - writing a level bit drives the pin immediately
// - in 16-bit mode upper counts lower overflows
module dual_mode_compare_timer (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic [3:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_event_pin,
  input  wire logic       i_event_edge_select,
  input  wire logic       i_upper_irq_enable,
  input  wire logic       i_lower_irq_enable,
  input  wire logic       i_run,
  output logic [7:0]      o_rdata,
  output logic            o_upper_toggle_pin,
  output logic            o_lower_toggle_pin,
  output logic            o_upper_irq,
  output logic            o_lower_irq
);
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic [7:0] ctrl_reg;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [7:0] armed_reg;
  logic [7:0] cmp_h_reg;
  logic [7:0] cmp_l_reg;
  logic [7:0] latch_reg;
  logic [7:0] rdata_reg;
  logic [4:0] presc_reg;
  logic       ev_prev_reg;
  logic       up_pin_reg;
  logic       lo_pin_reg;
  logic       up_irq_reg;
  logic       lo_irq_reg;
  logic       mode16;
  logic       ev_edge;
  logic       lo_tick;
  logic       up_tick;
  logic       lo_wrap;
  logic       up_wrap;
  logic [7:0] cnt_h;
  logic [7:0] cnt_l;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       wr_cnt_h;
  logic       wr_cnt_l;
  logic       wr_cmp_h;
  logic       wr_cmp_l;
  logic       up_cnt_wr;
  logic       up_cmp_wr;
  logic [7:0] up_wdata;
  logic       match_w;
  logic       match_l;
  logic       match_h8;
  logic       match_u;
  logic       lo_clr;
  logic       up_clr;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  // async assert, clocked release
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign wr_ctrl  = i_wr & (i_addr == timer_pkg::OFF_CTRL);
  assign wr_stat  = i_wr & (i_addr == timer_pkg::OFF_STAT);
  assign wr_cnt_h = i_wr & (i_addr == timer_pkg::OFF_CNT_H);
  assign wr_cnt_l = i_wr & (i_addr == timer_pkg::OFF_CNT_L);
  assign wr_cmp_h = i_wr & (i_addr == timer_pkg::OFF_CMP_H);
  assign wr_cmp_l = i_wr & (i_addr == timer_pkg::OFF_CMP_L);

  assign mode16 = ~ctrl_reg[timer_pkg::B_SEL_H + 2];

  // divide taps share one free-running prescaler
  function automatic logic tap(input logic [1:0] sel,
                               input logic [4:0] p);
    case (sel)
      timer_pkg::SEL_D32: tap = &p[4:0];
      timer_pkg::SEL_D16: tap = &p[3:0];
      timer_pkg::SEL_D4:  tap = &p[1:0];
      timer_pkg::SEL_D2:  tap = p[0];
      default:            tap = 1'b0;
    endcase
  endfunction

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= 5'h00;
    end else begin
      presc_reg <= presc_reg + 5'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev_reg <= 1'b0;
    end else begin
      ev_prev_reg <= i_event_pin;
    end
  end
  // one sample per clock, so pulses under one clock may be missed
  assign ev_edge = i_event_edge_select ? (i_event_pin & ~ev_prev_reg)
                                       : (~i_event_pin & ev_prev_reg);

  assign lo_tick = i_run & (ctrl_reg[timer_pkg::B_SEL_L + 2]
                   ? tap(ctrl_reg[timer_pkg::B_SEL_L +: 2], presc_reg)
                   : ev_edge);
  assign up_tick = mode16 ? lo_wrap
                   : i_run & tap(ctrl_reg[timer_pkg::B_SEL_H +: 2],
                                 presc_reg);

  // compare write in the match cycle inhibits the match
  assign match_w  = lo_tick & ~wr_cmp_l &
                    ({cnt_h, cnt_l} == {cmp_h_reg, cmp_l_reg});
  assign match_l  = lo_tick & ~wr_cmp_l & (cnt_l == cmp_l_reg);
  assign match_h8 = up_tick & ~wr_cmp_h & (cnt_h == cmp_h_reg);
  assign match_u  = mode16 ? match_w : match_h8;

  assign lo_clr = mode16 ? (match_w & stat_reg[timer_pkg::B_CCLR_H])
                         : (match_l & stat_reg[timer_pkg::B_CCLR_L]);
  assign up_clr = match_u & stat_reg[timer_pkg::B_CCLR_H];

  assign up_cnt_wr = mode16 ? wr_cnt_l : wr_cnt_h;
  assign up_cmp_wr = mode16 ? wr_cmp_l : wr_cmp_h;
  assign up_wdata  = mode16 ? latch_reg : i_wdata;

  count_half u_lower (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_tick    (lo_tick),
    .i_clear   (lo_clr),
    .i_wr      (wr_cnt_l),
    .i_wdata   (i_wdata),
    .o_count   (cnt_l),
    .o_wrap    (lo_wrap)
  );

  count_half u_upper (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_tick    (up_tick),
    .i_clear   (up_clr),
    .i_wr      (up_cnt_wr),
    .i_wdata   (up_wdata),
    .o_count   (cnt_h),
    .o_wrap    (up_wrap)
  );

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= timer_pkg::RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_h_reg <= timer_pkg::RST_CMP;
      cmp_l_reg <= timer_pkg::RST_CMP;
    end else begin
      if (up_cmp_wr) begin
        cmp_h_reg <= up_wdata;
      end
      if (wr_cmp_l) begin
        cmp_l_reg <= i_wdata;
      end
    end
  end

  // latch shared by 16-bit writes and counter reads
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 8'h00;
    end else if (mode16 && (wr_cnt_h || wr_cmp_h)) begin
      latch_reg <= i_wdata;
    end else if (mode16 && i_rd && i_addr == timer_pkg::OFF_CNT_H) begin
      latch_reg <= cnt_l;
    end
  end

  // hardware set beats software clear
  assign flag_set = {up_wrap, match_u, 2'b00, lo_wrap, match_l, 2'b00};
  assign flag_clr = wr_stat ? (timer_pkg::FLAG_MASK & ~i_wdata & armed_reg)
                            : 8'h00;
  always_comb begin
    stat_next = stat_reg & ~flag_clr;
    if (wr_stat) begin
      stat_next = (i_wdata & ~timer_pkg::FLAG_MASK) |
                  (stat_next & timer_pkg::FLAG_MASK);
    end
    stat_next = stat_next | flag_set;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= timer_pkg::RST_STAT;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // a flag may only be cleared once it has been read as one
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 8'h00;
    end else if (wr_stat) begin
      armed_reg <= 8'h00;
    end else if (i_rd && i_addr == timer_pkg::OFF_STAT) begin
      armed_reg <= armed_reg | (stat_reg & timer_pkg::FLAG_MASK);
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        timer_pkg::OFF_STAT:  rdata_reg <= stat_reg;
        timer_pkg::OFF_CNT_H: rdata_reg <= cnt_h;
        timer_pkg::OFF_CNT_L: rdata_reg <= mode16 ? latch_reg : cnt_l;
        timer_pkg::OFF_CMP_H: rdata_reg <= cmp_h_reg;
        timer_pkg::OFF_CMP_L: rdata_reg <= cmp_l_reg;
        default:              rdata_reg <= timer_pkg::RD_NONE;
      endcase
    end
  end

  // level write wins over a match in the same cycle
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up_pin_reg <= 1'b0;
      lo_pin_reg <= 1'b0;
    end else if (wr_ctrl) begin
      up_pin_reg <= i_wdata[timer_pkg::B_TOL_H];
      lo_pin_reg <= i_wdata[timer_pkg::B_TOL_L];
    end else begin
      up_pin_reg <= up_pin_reg ^ match_u;
      lo_pin_reg <= lo_pin_reg ^ match_l;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up_irq_reg <= 1'b0;
      lo_irq_reg <= 1'b0;
    end else begin
      up_irq_reg <= i_upper_irq_enable & (match_u |
                    (up_wrap & stat_reg[timer_pkg::B_OVIE_H]));
      lo_irq_reg <= i_lower_irq_enable & (match_l |
                    (lo_wrap & stat_reg[timer_pkg::B_OVIE_L]));
    end
  end

  assign o_rdata            = rdata_reg;
  assign o_upper_toggle_pin = up_pin_reg;
  assign o_lower_toggle_pin = lo_pin_reg;
  assign o_upper_irq        = up_irq_reg;
  assign o_lower_irq        = lo_irq_reg;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  a_upper_ovf_set: assert property (
    up_wrap |=> stat_reg[7]) else $error("upper overflow not flagged");
  a_no_sw_set: assert property (
    wr_stat && i_wdata[6] && !stat_reg[6] && !match_u |=> !stat_reg[6])
    else $error("software set match flag");
  a_wide_clear: assert property (
    mode16 && match_w && stat_reg[4] && !wr_cnt_l && !wr_cnt_h
    |=> cnt_h == 8'h00 && cnt_l == 8'h00)
    else $error("wide counter not cleared on match");
  a_lower_flags: assert property (
    lo_wrap |=> stat_reg[3]) else $error("lower overflow not flagged");
  a_lower_match: assert property (
    match_l |=> stat_reg[2]) else $error("lower match not flagged");
  a_lower_clear: assert property (
    !mode16 && match_l && stat_reg[0] && !wr_cnt_l |=> cnt_l == 8'h00)
    else $error("lower counter not cleared");
  a_latch_load: assert property (
    mode16 && wr_cnt_h ##1 !i_wr ##1 wr_cnt_l && mode16
    |=> cnt_h == $past(i_wdata, 3) && cnt_l == $past(i_wdata))
    else $error("16-bit counter write wrong");
  a_read_pair: assert property (
    mode16 && i_rd && i_addr == 4'h8 && !wr_cmp_h && !wr_cnt_h
    ##1 (!i_wr && !i_rd) [*2]
    ##1 i_rd && i_addr == 4'h9 && mode16 |=> o_rdata == $past(cnt_l, 4))
    else $error("lower read did not return captured byte");
  a_cmp_read: assert property (
    i_rd && i_addr == 4'hA |=> o_rdata == $past(cmp_h_reg))
    else $error("compare read wrong");
  a_halted: assert property (
    !i_run && !i_wr |=> $stable(cnt_l) && $stable(cnt_h))
    else $error("counter moved while halted");
  a_pin_toggle: assert property (
    match_u && !wr_ctrl |=> up_pin_reg != $past(up_pin_reg))
    else $error("upper pin did not toggle");
  a_pin_level: assert property (
    wr_ctrl |=> lo_pin_reg == $past(i_wdata[3]))
    else $error("lower pin not at written level");
  a_upper_irq: assert property (
    mode16 && up_wrap && !stat_reg[5] && !match_u |=> !o_upper_irq)
    else $error("overflow irq without enable");

  c_wide_match: cover property (mode16 && match_w);
  c_eight_both: cover property (!mode16 && match_l ##[1:200] match_h8);
  c_flag_clear: cover property (stat_reg[7] ##1 !stat_reg[7]);
endmodule

// ---- tb/cpu_bus_model.sv ----
/*
  cpu side of the timer: byte reads and writes, event pulses.
  assumes one-cycle strobes taken at the rising edge of i_clk_sys.
*/
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rdata,
  output logic [3:0]      o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_wdata,
  output logic            o_event
);
  initial begin
    o_addr = 4'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
    o_event = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    // released bus shows no stale data
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    @(posedge i_clk_sys);
    #1 d = i_rdata;
  endtask
  // upper byte first, one idle clock between the two writes
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 4'h1, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 4'h1, v[7:0]);
  endtask
  // high held two clocks, low at least two
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      o_event <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      o_event <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
    end
  endtask
endmodule

// ---- tb/dual_mode_compare_timer_bench.sv ----
/*
  self-checking bench of the dual mode compare timer.
  assumes cpu_bus_model drives the bus and the event pin.
*/
`timescale 1ns/1ps
module dual_mode_compare_timer_bench;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        run = 1'b0;
  logic        edge_sel = 1'b1;
  logic        up_en = 1'b1;
  logic        lo_en = 1'b1;
  logic [3:0]  addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic        evt;
  logic [7:0]  rdata;
  logic        up_pin;
  logic        lo_pin;
  logic        up_irq;
  logic        lo_irq;
  logic [7:0]  b;
  logic [15:0] w;
  int          err_total = 0;
  int          n_checks = 0;
  int          n_up = 0;
  int          n_lo = 0;

  always #12.5 clk_sys = ~clk_sys;

  dual_mode_compare_timer dut (
    .i_clk_sys           (clk_sys),
    .i_reset_n           (reset_n),
    .i_addr              (addr),
    .i_wr                (wr),
    .i_rd                (rd),
    .i_wdata             (wdata),
    .i_event_pin         (evt),
    .i_event_edge_select (edge_sel),
    .i_upper_irq_enable  (up_en),
    .i_lower_irq_enable  (lo_en),
    .i_run               (run),
    .o_rdata             (rdata),
    .o_upper_toggle_pin  (up_pin),
    .o_lower_toggle_pin  (lo_pin),
    .o_upper_irq         (up_irq),
    .o_lower_irq         (lo_irq)
  );
  cpu_bus_model cpu (
    .i_clk_sys (clk_sys),
    .i_rdata   (rdata),
    .o_addr    (addr),
    .o_wr      (wr),
    .o_rd      (rd),
    .o_wdata   (wdata),
    .o_event   (evt)
  );

  always @(posedge clk_sys) begin
    if (up_irq === 1'b1) n_up++;
    if (lo_irq === 1'b1) n_lo++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // bounded wait for a lower irq pulse, then halt counting
  task automatic wait_lo(input int start);
    for (int i = 0; i < 80 && n_lo == start; i++) @(posedge clk_sys);
    run <= 1'b0;
    check(16'(n_lo - start), 16'h0001);
  endtask

  task automatic t_reset;
    cpu.rd(4'h7, b);
    check(b, 8'h00);
    cpu.rd16(4'h8, w);
    check(w, 16'h0000);
    cpu.rd16(4'hA, w);
    check(w, 16'hFFFF);
    cpu.rd(4'h6, b);
    check(b, 8'hFF);
    cpu.rd(4'h0, b);
    check(b, 8'hFF);
    check({up_pin, lo_pin}, 2'b00);
    $display("reset test done");
  endtask

  task automatic t_wide;
    cpu.wr16(4'h8, 16'hAA55);
    cpu.rd16(4'h8, w);
    check(w, 16'hAA55);
    cpu.wr16(4'hA, 16'h1234);
    cpu.rd(4'hB, b);
    check(b, 8'h34);
    cpu.rd(4'hA, b);
    check(b, 8'h12);
    $display("wide access test done");
  endtask

  task automatic t_level;
    cpu.wr(4'h6, 8'h88);
    @(posedge clk_sys);
    #1 check({up_pin, lo_pin}, 2'b11);
    cpu.wr(4'h6, 8'h00);
    @(posedge clk_sys);
    #1 check({up_pin, lo_pin}, 2'b00);
    $display("level test done");
  endtask

  // 8-bit mode, lower /2, clear on match at 3
  task automatic t_match8;
    cpu.wr(4'h6, 8'h47);
    cpu.wr(4'h7, 8'h01);
    cpu.wr(4'hB, 8'h03);
    cpu.wr(4'h9, 8'h00);
    run <= 1'b1;
    wait_lo(n_lo);
    cpu.rd(4'h7, b);
    check(b, 8'h05);
    check(lo_pin, 1'b1);
    cpu.rd(4'h9, b);
    check(b <= 8'h03, 1'b1);
    cpu.wr(4'h7, 8'h01);
    cpu.rd(4'h7, b);
    check(b, 8'h01);
    cpu.wr(4'h7, 8'hFF);
    cpu.rd(4'h7, b);
    check(b, 8'h33);
    cpu.wr(4'h7, 8'h00);
    $display("lower match test done");
  endtask

  task automatic t_ovf8;
    cpu.wr(4'h7, 8'h02);
    cpu.wr(4'hB, 8'h80);
    cpu.wr(4'h9, 8'hFD);
    run <= 1'b1;
    wait_lo(n_lo);
    cpu.rd(4'h7, b);
    check(b, 8'h0A);
    cpu.wr(4'h7, 8'h0A);
    cpu.rd(4'h7, b);
    check(b, 8'h0A);
    cpu.wr(4'h7, 8'h02);
    cpu.rd(4'h7, b);
    check(b, 8'h02);
    $display("lower overflow test done");
  endtask

  // 16-bit mode on rising event edges, then one falling edge
  task automatic t_wide16;
    int s;
    cpu.wr(4'h6, 8'h00);
    cpu.wr(4'h7, 8'h20);
    cpu.wr16(4'h8, 16'hFFFE);
    run <= 1'b1;
    s = n_up;
    cpu.pulse(2);
    cpu.rd16(4'h8, w);
    check(w, 16'h0000);
    cpu.rd(4'h7, b);
    check(b & 8'hF0, 8'hA0);
    check(16'(n_up - s), 16'h0001);
    cpu.wr(4'h7, 8'h20);
    cpu.rd(4'h7, b);
    check(b & 8'hF0, 8'h20);
    cpu.wr(4'h7, 8'h10);
    cpu.wr16(4'h8, 16'h0100);
    cpu.wr16(4'hA, 16'h0102);
    s = n_up;
    cpu.pulse(2);
    cpu.rd16(4'h8, w);
    check(w, 16'h0102);
    cpu.rd(4'h7, b);
    check(b & 8'hF0, 8'h10);
    cpu.pulse(1);
    cpu.rd16(4'h8, w);
    check(w, 16'h0000);
    cpu.rd(4'h7, b);
    check(b & 8'hF0, 8'h50);
    check(up_pin, 1'b1);
    check(16'(n_up - s), 16'h0001);
    @(posedge clk_sys);
    edge_sel <= 1'b0;
    cpu.pulse(1);
    cpu.rd16(4'h8, w);
    check(w, 16'h0001);
    $display("wide mode test done");
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_wide();
    t_level();
    t_match8();
    t_ovf8();
    t_wide16();
    tally_and_finish();
  end

  // tests need a few hundred cycles; the limit is 20000
  initial begin
    #(25 * 20000);
    err_total++;
    tally_and_finish();
  end
endmodule
